// File: odc_discovery_control.sv
// Purpose: Discovery state machine and periodic OAMPDU transmit control
// Assumes: Client inputs and received header are synchronous to sys_clk
// Notes: One transmit order at a time; tx_ready paces orders from the multiplexer
`timescale 1ns/1ps
module odc_discovery_control import odc_pkg::*; #(
   parameter int unsigned LOST_LINK_CYCLES = ODC_LOST_LINK_CYC,
   parameter int unsigned PDU_TIMER_CYCLES = ODC_PDU_TIMER_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic oam_enable,
   input wire logic mode_active,
   input wire odc_client_t client,
   input wire odc_rx_t rx_hdr,
   input wire logic req_pending,
   input wire logic tx_ready,
   output odc_tx_t tx_order,
   output logic tx_valid,
   output odc_pdu_mode_t local_pdu,
   output logic local_stable,
   output logic local_evaluating,
   output logic lost_link_done,
   output logic rx_oampdu,
   output logic rx_to_client
);
   typedef enum logic [2:0] {
      ST_FAULT, ST_ACTIVE_SEND_LOCAL, ST_PASSIVE_WAIT,
      ST_SEND_LOCAL_REMOTE, ST_SEND_LOCAL_REMOTE_OK, ST_SEND_ANY
   } odc_disc_state_t;
   typedef enum logic [1:0] {TX_RESET, TX_WAIT, TX_SEND} odc_tx_state_t;

   if (LOST_LINK_CYCLES < 2 || PDU_TIMER_CYCLES < 2) begin : g_short_timer
      $error("timer counts too small");
   end
   if (LOST_LINK_CYCLES <= PDU_TIMER_CYCLES) begin : g_timer_order
      $error("lost link must outlast pdu timer");
   end

   odc_disc_state_t state, next_state;
   odc_tx_state_t tx_state, next_tx_state;
   logic [3:0] pdu_cnt;
   logic sent_in_window;
   logic tx_critical;

   // Internal OAM reset while sublayer reset or disabled
   wire oam_begin = reset || !oam_enable;

   // Frame qualification
   wire is_oampdu = rx_hdr.valid && (rx_hdr.dest == ODC_SLOW_MCAST) &&
                    (rx_hdr.len_type == ODC_SLOW_TYPE) && (rx_hdr.subtype == ODC_OAM_SUBTYPE);
   wire good_rx = is_oampdu && rx_hdr.rx_ok;
   wire good_info = good_rx && rx_hdr.is_info;
   wire rx_local_tlv = good_info && rx_hdr.has_local_tlv;

   // Peer state arrives only through client flags
   wire peer_known = client.remote_state_valid;
   wire peer_ok = client.remote_stable && !client.remote_evaluating;

   // Pending request class
   wire crit_flags = client.dying_gasp || !client.link_ok || client.critical_event;
   odc_req_t pdu_req;
   assign pdu_req = !req_pending ? ODC_REQ_NONE : (crit_flags ? ODC_REQ_CRITICAL : ODC_REQ_NORMAL);

   // Valid request terms
   wire valid_normal = (local_pdu != ODC_RX_INFO) && (pdu_req == ODC_REQ_NORMAL) && (pdu_cnt != 4'h0);
   wire valid_crit = (local_pdu == ODC_ANY) && (pdu_req == ODC_REQ_CRITICAL);
   wire valid_pdu_req = valid_normal || valid_crit;

   // Timers derived from clock rate
   logic pdu_timer_done;
   wire pdu_timer_start = (tx_state == TX_RESET);
   // Lost-link timer starts on leaving fault and restarts on each good OAMPDU
   wire lost_start = (state == ST_FAULT) ? (next_state != ST_FAULT) : good_rx;
   wire lost_stop = (next_state == ST_FAULT);

   odc_timer #(.CYCLES(LOST_LINK_CYCLES)) u_lost_timer (
      .sys_clk(sys_clk),
      .reset(oam_begin),
      .start(lost_start),
      .stop(lost_stop),
      .done(lost_link_done)
   );

   odc_timer #(.CYCLES(PDU_TIMER_CYCLES)) u_pdu_timer (
      .sys_clk(sys_clk),
      .reset(oam_begin),
      .start(pdu_timer_start),
      .stop(1'b0),
      .done(pdu_timer_done)
   );

   // Discovery next state
   always_comb begin
      next_state = state;
      case (state)
         // Hold fault while link fails
         ST_FAULT: begin
            if (client.link_ok) begin
               next_state = mode_active ? ST_ACTIVE_SEND_LOCAL : ST_PASSIVE_WAIT;
            end
         end
         ST_ACTIVE_SEND_LOCAL, ST_PASSIVE_WAIT: begin
            if (rx_local_tlv || peer_known) begin
               next_state = ST_SEND_LOCAL_REMOTE;
            end
         end
         ST_SEND_LOCAL_REMOTE: begin
            if (peer_known && client.satisfied) begin
               next_state = ST_SEND_LOCAL_REMOTE_OK;
            end
         end
         ST_SEND_LOCAL_REMOTE_OK: begin
            if (!client.satisfied) begin
               next_state = ST_SEND_LOCAL_REMOTE;
            end else if (peer_ok) begin
               next_state = ST_SEND_ANY;
            end
         end
         ST_SEND_ANY: begin
            if (!client.satisfied) begin
               next_state = ST_SEND_LOCAL_REMOTE;
            end else if (!peer_ok) begin
               next_state = ST_SEND_LOCAL_REMOTE_OK;
            end
         end
         default: next_state = ST_FAULT;
      endcase
      // Global return to fault
      if (lost_link_done || !client.link_ok) begin
         next_state = ST_FAULT;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (oam_begin) begin
         state <= ST_FAULT;
      end else begin
         state <= next_state;
      end
   end

   // Mode and Discovery flags per state
   always_ff @(posedge sys_clk) begin
      if (oam_begin) begin
         local_pdu <= ODC_RX_INFO;
         local_stable <= 1'b0;
         local_evaluating <= 1'b1;
      end else begin
         case (next_state)
            ST_FAULT: begin
               local_pdu <= client.link_ok ? ODC_RX_INFO : ODC_LF_INFO;
               local_stable <= 1'b0;
               local_evaluating <= 1'b1;
            end
            ST_ACTIVE_SEND_LOCAL, ST_SEND_LOCAL_REMOTE: begin
               local_pdu <= ODC_INFO;
               local_stable <= 1'b0;
               local_evaluating <= !peer_known;
            end
            ST_PASSIVE_WAIT: begin
               local_pdu <= ODC_RX_INFO;
               local_stable <= 1'b0;
               local_evaluating <= 1'b1;
            end
            ST_SEND_LOCAL_REMOTE_OK: begin
               local_pdu <= ODC_INFO;
               local_stable <= 1'b1;
               local_evaluating <= 1'b0;
            end
            ST_SEND_ANY: begin
               local_pdu <= ODC_ANY;
               local_stable <= 1'b1;
               local_evaluating <= 1'b0;
            end
            default: begin
               local_pdu <= ODC_RX_INFO;
               local_stable <= 1'b0;
               local_evaluating <= 1'b1;
            end
         endcase
      end
   end

   // Transmit process: request or timer keepalive
   wire keepalive = pdu_timer_done && !sent_in_window && !valid_pdu_req && (local_pdu != ODC_RX_INFO);
   always_comb begin
      next_tx_state = tx_state;
      case (tx_state)
         TX_RESET: next_tx_state = TX_WAIT;
         TX_WAIT: begin
            if (valid_pdu_req || keepalive) begin
               next_tx_state = TX_SEND;
            end else if (pdu_timer_done) begin
               next_tx_state = TX_RESET;
            end
         end
         TX_SEND: begin
            // An order caught by a fall to RX_INFO is dropped, or it would stand forever
            if (local_pdu == ODC_RX_INFO) begin
               next_tx_state = TX_RESET;
            end else if (tx_ready) begin
               next_tx_state = pdu_timer_done ? TX_RESET : TX_WAIT;
            end
         end
         default: next_tx_state = TX_RESET;
      endcase
   end

   // Order contents by local_pdu and Discovery state
   odc_tx_t next_order;
   always_comb begin
      next_order = '0;
      next_order.link_fault = !client.link_ok;
      next_order.dying_gasp = client.dying_gasp;
      next_order.critical_event = client.critical_event;
      next_order.local_stable = local_stable;
      next_order.local_evaluating = local_evaluating;
      if (local_pdu == ODC_LF_INFO) begin
         next_order.kind = ODC_TX_LF_INFO;
         next_order.tlvs = ODC_TLV_NONE;
         next_order.link_fault = 1'b1;
      end else begin
         next_order.kind = (local_pdu == ODC_ANY && !keepalive) ? ODC_TX_REQ : ODC_TX_INFO;
         next_order.tlvs = (state == ST_ACTIVE_SEND_LOCAL) ? ODC_TLV_LOCAL : ODC_TLV_LOCAL_REMOTE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (oam_begin) begin
         tx_state <= TX_RESET;
         tx_order <= '0;
         tx_critical <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         if (tx_state == TX_WAIT && next_tx_state == TX_SEND) begin
            tx_order <= next_order;
            tx_critical <= valid_crit && !valid_normal;
         end
      end
   end

   assign tx_valid = (tx_state == TX_SEND) && (local_pdu != ODC_RX_INFO);

   // Rate cap: reload on transmit reset, decrement on non-critical send
   always_ff @(posedge sys_clk) begin
      if (oam_begin || tx_state == TX_RESET) begin
         pdu_cnt <= ODC_PDU_CNT_MAX;
         sent_in_window <= 1'b0;
      end else if (tx_valid && tx_ready) begin
         sent_in_window <= 1'b1;
         if (!tx_critical && pdu_cnt != 4'h0) begin
            pdu_cnt <= pdu_cnt - 4'h1;
         end
      end
   end

   // Receive pass filter: Information always, others only in ANY
   always_ff @(posedge sys_clk) begin
      if (oam_begin) begin
         rx_oampdu <= 1'b0;
         rx_to_client <= 1'b0;
      end else begin
         rx_oampdu <= good_rx;
         rx_to_client <= good_rx && (rx_hdr.is_info || local_pdu == ODC_ANY);
      end
   end

   chk_fault_on_fail: assert property (@(posedge sys_clk) disable iff (oam_begin)
      !client.link_ok |=> state == ST_FAULT && local_pdu == ODC_LF_INFO) else $error("link fail not faulted");
   chk_rx_info_quiet: assert property (@(posedge sys_clk) disable iff (oam_begin)
      local_pdu == ODC_RX_INFO |-> !tx_valid) else $error("sent under RX_INFO");
   chk_any_needs_stable: assert property (@(posedge sys_clk) disable iff (oam_begin)
      local_pdu == ODC_ANY |-> local_stable && !local_evaluating) else $error("ANY without stable");
   chk_cnt_bound: assert property (@(posedge sys_clk) disable iff (oam_begin)
      pdu_cnt <= ODC_PDU_CNT_MAX) else $error("pdu count above cap");
   chk_cnt_reload: assert property (@(posedge sys_clk) disable iff (oam_begin)
      tx_state == TX_RESET |=> pdu_cnt == ODC_PDU_CNT_MAX) else $error("count not reloaded");
   chk_lost_expiry: assert property (@(posedge sys_clk) disable iff (oam_begin)
      lost_link_done |=> state == ST_FAULT) else $error("lost link not faulted");
   chk_lf_no_tlv: assert property (@(posedge sys_clk) disable iff (oam_begin)
      tx_valid && tx_order.kind == ODC_TX_LF_INFO |-> tx_order.tlvs == ODC_TLV_NONE && tx_order.link_fault)
      else $error("link fault order carries TLVs");
   chk_passive_silent: assert property (@(posedge sys_clk) disable iff (oam_begin)
      state == ST_PASSIVE_WAIT && $past(state) == ST_PASSIVE_WAIT |-> !tx_valid) else $error("passive sent early");
   chk_fault_unstable: assert property (@(posedge sys_clk) disable iff (oam_begin)
      state == ST_FAULT |-> !local_stable) else $error("stable set in fault");
endmodule : odc_discovery_control

// File: odc_discovery_control_test.sv
// Purpose: Self-checking bench for the discovery control block
// Assumes: Timers shortened to PDU 100 and lost-link 600 cycles
// Notes: Rate windows are not aligned to the bench, so counts are checked as ranges
`timescale 1ns/1ps
module odc_discovery_control_test;
   import odc_pkg::*;
   localparam int PDU = 100;
   localparam int LOST = 600;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic oam_enable = 1'b1;
   logic mode_active = 1'b0;
   odc_client_t client = '0;
   odc_rx_t rx_hdr = '0;
   logic req_pending = 1'b0;
   logic tx_ready;
   odc_tx_t tx_order;
   logic tx_valid;
   odc_pdu_mode_t local_pdu;
   logic local_stable;
   logic local_evaluating;
   logic lost_link_done;
   logic rx_oampdu;
   logic rx_to_client;
   logic [3:0] slow = 4'h0;
   int taken;
   int bad;
   odc_tx_t last;
   int err_total = 0;
   int comparisons = 0;
   int n0;
   int k;
   always #50 sys_clk = ~sys_clk;

   odc_discovery_control #(.LOST_LINK_CYCLES(LOST), .PDU_TIMER_CYCLES(PDU)) dut (.sys_clk(sys_clk),
      .reset(reset), .oam_enable(oam_enable), .mode_active(mode_active), .client(client), .rx_hdr(rx_hdr),
      .req_pending(req_pending), .tx_ready(tx_ready), .tx_order(tx_order), .tx_valid(tx_valid),
      .local_pdu(local_pdu), .local_stable(local_stable), .local_evaluating(local_evaluating),
      .lost_link_done(lost_link_done), .rx_oampdu(rx_oampdu), .rx_to_client(rx_to_client));
   odc_mux_model peer (.sys_clk(sys_clk), .reset(reset), .tx_valid(tx_valid), .tx_order(tx_order),
      .local_pdu(local_pdu), .slow(slow), .tx_ready(tx_ready), .taken(taken), .bad(bad), .last(last));

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic send_rx(input logic [47:0] d, input logic [15:0] t, input logic [7:0] s, input logic ok,
                          input logic info, input logic exp, input logic exp_cl);
      logic seen;
      logic seen_cl;
      rx_hdr = '{valid: 1'b1, dest: d, len_type: t, subtype: s, rx_ok: ok, is_info: info, has_local_tlv: 1'b1};
      tick(1);
      rx_hdr.valid = 1'b0;
      seen = rx_oampdu;
      seen_cl = rx_to_client;
      tick(1);
      seen = seen | rx_oampdu;
      seen_cl = seen_cl | rx_to_client;
      check("rx_oampdu", exp, seen);
      check("rx_to_client", exp_cl, seen_cl);
   endtask : send_rx

   task automatic report_and_stop;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      tick(2);
      check("pdu in reset", ODC_RX_INFO, local_pdu);
      check("eval in reset", 1'b1, local_evaluating);
      tick(1);
      reset = 1'b0;
      client.unidirectional = 1'b1;
      tick(2);
      check("pdu link fail", ODC_LF_INFO, local_pdu);
      tick(2 * PDU + 10);
      check("lf kind", ODC_TX_LF_INFO, last.kind);
      check("lf tlvs", ODC_TLV_NONE, last.tlvs);
      check("lf flag", 1'b1, last.link_fault);
      oam_enable = 1'b0;
      tick(2);
      check("pdu disabled", ODC_RX_INFO, local_pdu);
      oam_enable = 1'b1;
      client.link_ok = 1'b1;
      tick(2);
      check("pdu passive", ODC_RX_INFO, local_pdu);
      // Request raised on purpose: it must never be taken under RX_INFO
      n0 = taken;
      req_pending = 1'b1;
      tick(2 * PDU);
      req_pending = 1'b0;
      check("refused", n0, taken);
      // Non-Information frame: seen as OAMPDU, kept from the client, no Discovery step
      send_rx(ODC_SLOW_MCAST, ODC_SLOW_TYPE, ODC_OAM_SUBTYPE, 1'b1, 1'b0, 1'b1, 1'b0);
      check("passive held", ODC_RX_INFO, local_pdu);
      send_rx(ODC_SLOW_MCAST, ODC_SLOW_TYPE, ODC_OAM_SUBTYPE, 1'b1, 1'b1, 1'b1, 1'b1);
      client.remote_state_valid = 1'b1;
      tick(2);
      check("pdu local remote", ODC_INFO, local_pdu);
      check("eval after peer", 1'b0, local_evaluating);
      client.satisfied = 1'b1;
      tick(2);
      check("stable", 1'b1, local_stable);
      check("not any yet", 1'b1, local_pdu !== ODC_ANY);
      client.remote_stable = 1'b1;
      tick(2);
      check("pdu any", ODC_ANY, local_pdu);
      send_rx(ODC_SLOW_MCAST ^ 48'h1, ODC_SLOW_TYPE, ODC_OAM_SUBTYPE, 1'b1, 1'b1, 1'b0, 1'b0);
      send_rx(ODC_SLOW_MCAST, ODC_SLOW_TYPE ^ 16'h1, ODC_OAM_SUBTYPE, 1'b1, 1'b1, 1'b0, 1'b0);
      send_rx(ODC_SLOW_MCAST, ODC_SLOW_TYPE, ODC_OAM_SUBTYPE ^ 8'h1, 1'b1, 1'b1, 1'b0, 1'b0);
      send_rx(ODC_SLOW_MCAST, ODC_SLOW_TYPE, ODC_OAM_SUBTYPE, 1'b0, 1'b1, 1'b0, 1'b0);
      // Under ANY every good OAMPDU reaches the client, Information or not
      send_rx(ODC_SLOW_MCAST, ODC_SLOW_TYPE, ODC_OAM_SUBTYPE, 1'b1, 1'b0, 1'b1, 1'b1);
      // Normal requests with a stalling multiplexer: ten per window at most
      slow = 4'h2;
      n0 = taken;
      req_pending = 1'b1;
      tick(4 * PDU);
      check("normal rate", 1'b1, (taken - n0 >= 30) && (taken - n0 <= 50));
      check("normal kind", ODC_TX_REQ, last.kind);
      check("order stable", 1'b1, last.local_stable);
      check("order eval", 1'b0, last.local_evaluating);
      send_rx(ODC_SLOW_MCAST, ODC_SLOW_TYPE, ODC_OAM_SUBTYPE, 1'b1, 1'b1, 1'b1, 1'b1);
      slow = 4'h0;
      client.critical_event = 1'b1;
      n0 = taken;
      tick(3 * PDU);
      check("critical rate", 1'b1, taken - n0 > 45);
      check("critical flag", 1'b1, last.critical_event);
      req_pending = 1'b0;
      client.critical_event = 1'b0;
      // Last good OAMPDU restarts the lost-link timer, so the wait is timed from here
      send_rx(ODC_SLOW_MCAST, ODC_SLOW_TYPE, ODC_OAM_SUBTYPE, 1'b1, 1'b1, 1'b1, 1'b1);
      k = 0;
      while (lost_link_done !== 1'b1 && k < LOST + 100) begin
         tick(1);
         k++;
      end
      check("lost time", 1'b1, (k >= LOST * 9 / 10 - 10) && (k <= LOST * 11 / 10));
      tick(2);
      check("pdu after lost", ODC_RX_INFO, local_pdu);
      check("stable cleared", 1'b0, local_stable);
      client = '0;
      mode_active = 1'b1;
      tick(2);
      check("pdu fail again", ODC_LF_INFO, local_pdu);
      client.link_ok = 1'b1;
      tick(2);
      check("pdu active", ODC_INFO, local_pdu);
      tick(2 * PDU + 10);
      check("keepalive kind", ODC_TX_INFO, last.kind);
      check("keepalive tlvs", ODC_TLV_LOCAL, last.tlvs);
      check("mode breaches", 0, bad);
      report_and_stop();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      report_and_stop();
   end
endmodule : odc_discovery_control_test

// File: odc_mux_model.sv
// Purpose: Multiplexer-side partner that takes transmit orders from the control block
// Assumes: Orders stand until tx_ready is seen high at an edge
// Notes: slow sets the stall before ready; bad counts orders issued under RX_INFO and non-link-fault orders issued under link-fault mode
`timescale 1ns/1ps
module odc_mux_model import odc_pkg::*; (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic tx_valid,
   input wire odc_tx_t tx_order,
   input wire odc_pdu_mode_t local_pdu,
   input wire logic [3:0] slow,
   output logic tx_ready,
   output int taken,
   output int bad,
   output odc_tx_t last
);
   logic [3:0] waited;
   logic prev_valid;
   odc_pdu_mode_t prev_mode;
   initial begin
      tx_ready = 1'b0;
      taken = 0;
      bad = 0;
      waited = 4'h0;
      last = '0;
      prev_valid = 1'b0;
      prev_mode = ODC_RX_INFO;
   end
   always @(posedge sys_clk) begin
      prev_valid <= tx_valid;
      prev_mode <= local_pdu;
      // Judge against the mode seen when the order was issued, not the one after
      if (tx_valid && !prev_valid && prev_mode == ODC_RX_INFO) begin
         bad <= bad + 1;
      end
      if (tx_valid && !prev_valid && prev_mode == ODC_LF_INFO && tx_order.kind != ODC_TX_LF_INFO) begin
         bad <= bad + 1;
      end
      if (reset || !tx_valid) begin
         tx_ready <= 1'b0;
         waited <= 4'h0;
      end else if (tx_ready) begin
         taken <= taken + 1;
         last <= tx_order;
         tx_ready <= 1'b0;
         waited <= 4'h0;
      end else if (waited >= slow) begin
         tx_ready <= 1'b1;
      end else begin
         waited <= waited + 4'h1;
      end
   end
endmodule : odc_mux_model

// File: odc_pkg.sv
// Purpose: Shared types and constants for the OAM discovery control block
// Assumes: 10 MHz system clock
// Notes: Timer figures are kept in their own unit and converted to cycles
package odc_pkg;
   localparam int unsigned ODC_CLK_HZ = 10000000;
   localparam int unsigned ODC_LOST_LINK_S = 5;
   localparam int unsigned ODC_PDU_TIMER_S = 1;
   localparam int unsigned ODC_LOST_LINK_CYC = ODC_LOST_LINK_S * ODC_CLK_HZ;
   localparam int unsigned ODC_PDU_TIMER_CYC = ODC_PDU_TIMER_S * ODC_CLK_HZ;
   localparam logic [3:0] ODC_PDU_CNT_MAX = 4'hA;
   localparam logic [47:0] ODC_SLOW_MCAST = 48'h0180C2000002;
   localparam logic [15:0] ODC_SLOW_TYPE = 16'h8809;
   localparam logic [7:0] ODC_OAM_SUBTYPE = 8'h03;

   typedef enum logic [1:0] {ODC_LF_INFO, ODC_RX_INFO, ODC_INFO, ODC_ANY} odc_pdu_mode_t;
   typedef enum logic [1:0] {ODC_REQ_NONE, ODC_REQ_CRITICAL, ODC_REQ_NORMAL} odc_req_t;
   typedef enum logic [1:0] {ODC_TX_NONE, ODC_TX_LF_INFO, ODC_TX_INFO, ODC_TX_REQ} odc_tx_kind_t;
   typedef enum logic [1:0] {ODC_TLV_NONE, ODC_TLV_LOCAL, ODC_TLV_LOCAL_REMOTE} odc_tlv_t;

   // Parameters given by the OAM client
   typedef struct packed {
      logic link_ok;
      logic satisfied;
      logic unidirectional;
      logic remote_stable;
      logic remote_evaluating;
      logic remote_state_valid;
      logic dying_gasp;
      logic critical_event;
   } odc_client_t;

   // Header fields of a received frame
   typedef struct packed {
      logic valid;
      logic [47:0] dest;
      logic [15:0] len_type;
      logic [7:0] subtype;
      logic rx_ok;
      logic is_info;
      logic has_local_tlv;
   } odc_rx_t;

   // Transmit order handed to the multiplexer
   typedef struct packed {
      odc_tx_kind_t kind;
      odc_tlv_t tlvs;
      logic link_fault;
      logic dying_gasp;
      logic critical_event;
      logic local_stable;
      logic local_evaluating;
   } odc_tx_t;
endpackage : odc_pkg

// File: odc_timer.sv
// Purpose: Stoppable one-shot timer with a done level
// Assumes: start and stop come from logic on sys_clk
// Notes: Done holds until restarted or stopped
`timescale 1ns/1ps
module odc_timer import odc_pkg::*; #(
   parameter int unsigned CYCLES = 10
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic stop,
   output logic done
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] count;
   logic running;

   if (CYCLES < 2) begin : g_short_count
      $error("odc_timer needs at least two cycles");
   end

   // Stop clears the count and halts it until the next start
   always_ff @(posedge sys_clk) begin
      if (reset || stop) begin
         count <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         count <= W'(CYCLES - 1);
         running <= 1'b1;
         done <= 1'b0;
      end else if (running) begin
         count <= count - 1'b1;
         running <= (count != '0);
         done <= (count == '0);
      end
   end

   chk_stop_clears: assert property (@(posedge sys_clk) disable iff (reset)
      stop |=> !done && !running) else $error("timer not cleared by stop");
endmodule : odc_timer
